//--- dresl_pkg.sv
// Constants, widths, offsets and helper functions for the dual-rate edge speed law
package dresl_pkg;
	// Data path widths
	localparam int DEV_W = 16;
	localparam int SPD_W = 8;
	localparam int PCT_W = 7;
	localparam int QUO_W = DEV_W + SPD_W;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// Register offsets (word addresses on the plain register port)
	localparam logic [ADDR_W-1:0] OFS_PROP_RANGE = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_WIN_PCT = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_SPD_PCT = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_MAX_SPEED = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_LAST_SPEED = 4'h5;

	// Status register bit positions
	localparam int STAT_BUSY_BIT = 15;
	localparam int STAT_WIN_BIT = 14;

	// Proportional range in 0.1 mm: default 10.0 mm, limits -2000.0 .. 2000.0 mm
	localparam logic signed [DEV_W-1:0] RANGE_DEF = 16'sh0064;
	localparam logic signed [DEV_W-1:0] RANGE_MIN = 16'shB1E0;
	localparam logic signed [DEV_W-1:0] RANGE_MAX = 16'sh4E20;

	// Percentage settings
	localparam logic [PCT_W-1:0] PCT_MIN = 7'h0A;
	localparam logic [PCT_W-1:0] PCT_MAX = 7'h64;
	localparam logic [PCT_W-1:0] PCT_SCALE = 7'h64;
	localparam logic [PCT_W-1:0] WIN_PCT_DEF = 7'h1E;
	localparam logic [PCT_W-1:0] SPD_PCT_DEF = 7'h32;

	// Maximum automatic speed in mm/s
	localparam logic [SPD_W-1:0] SPEED_LIM = 8'hB4;
	localparam logic [SPD_W-1:0] SPEED_DEF = 8'h50;

	// Magnitude of a signed deviation or range
	function automatic logic [DEV_W-1:0] dresl_abs(input logic signed [DEV_W-1:0] v);
		return v[DEV_W-1] ? DEV_W'(-v) : DEV_W'(v);
	endfunction : dresl_abs

	// Bring a written percentage into its permitted span
	function automatic logic [PCT_W-1:0] dresl_clamp_pct(input logic [DATA_W-1:0] v);
		if (v < DATA_W'(PCT_MIN))
			return PCT_MIN;
		else if (v > DATA_W'(PCT_MAX))
			return PCT_MAX;
		else
			return v[PCT_W-1:0];
	endfunction : dresl_clamp_pct
endpackage : dresl_pkg

//--- dresl_divider.sv
// Iterative unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module dresl_divider #(
	parameter int N_W = 24,
	parameter int D_W = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [N_W-1:0] dividend,
	input wire logic [D_W-1:0] divisor,
	output logic done,
	output logic [N_W-1:0] quotient
);
	logic [D_W:0] rem;
	logic [D_W-1:0] dvs;
	logic [5:0] cnt;
	wire [D_W:0] shifted = {rem[D_W-1:0], quotient[N_W-1]};
	wire [D_W+1:0] trial = {1'b0, shifted} - {2'b00, dvs};
	wire fits = ~trial[D_W+1];

	// Load on start, then shift and subtract until the count runs out
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			rem <= '0;
			dvs <= '0;
			cnt <= '0;
			done <= 1'b0;
			quotient <= '0;
		end
		else if (start)
		begin
			rem <= '0;
			dvs <= divisor;
			cnt <= 6'(N_W);
			done <= 1'b0;
			quotient <= dividend;
		end
		else if (cnt != 6'h00)
		begin
			rem <= fits ? trial[D_W:0] : shifted;
			quotient <= {quotient[N_W-2:0], fits};
			cnt <= cnt - 6'h01;
			done <= (cnt == 6'h01);
		end
		else
			done <= 1'b0;
	end
endmodule : dresl_divider

//--- dresl_limit.sv
// Dual-rate window test and active speed limit
`timescale 1ns/1ps
module dresl_limit
	import dresl_pkg::*;
(
	input wire logic [DEV_W-1:0] abs_dev,
	input wire logic [DEV_W-1:0] abs_range,
	input wire logic [PCT_W-1:0] win_pct,
	input wire logic [PCT_W-1:0] spd_pct,
	input wire logic [SPD_W-1:0] max_speed,
	output logic in_window,
	output logic [SPD_W-1:0] limit
);
	// Compare |dev| * 100 against |range| * percent, avoiding a divide
	wire [23:0] dev_scaled = 24'(abs_dev) * 24'(PCT_SCALE);
	wire [23:0] win_scaled = 24'(abs_range) * 24'(win_pct);
	// Reduced speed as a percentage of the maximum automatic speed
	wire [14:0] red_prod = 15'(max_speed) * 15'(spd_pct);
	wire [14:0] red_quot = red_prod / 15'(PCT_SCALE);
	wire [SPD_W-1:0] reduced = red_quot[SPD_W-1:0];

	assign in_window = (dev_scaled <= win_scaled);
	assign limit = in_window ? reduced : max_speed;
endmodule : dresl_limit

//--- dresl_speed_law.sv
// Top of the dual-rate edge speed law: settings, sequencing and speed clamp
`timescale 1ns/1ps
module dresl_speed_law
	import dresl_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] address,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	input wire logic signed [DEV_W-1:0] edge_dev,
	input wire logic edge_valid,
	output logic edge_ready,
	output logic signed [SPD_W:0] speed_cmd,
	output logic speed_valid,
	output logic in_window
);
	typedef enum logic [1:0] {
		DRESL_IDLE = 2'b01,
		DRESL_DIV = 2'b10
	} dresl_state_t;

	dresl_state_t state;
	dresl_state_t next_state;
	logic signed [DEV_W-1:0] prop_range_setting;
	logic [PCT_W-1:0] dual_window_percent;
	logic [PCT_W-1:0] dual_speed_percent;
	logic [SPD_W-1:0] max_auto_speed;
	logic neg_lat;
	logic win_lat;
	logic [SPD_W-1:0] limit_lat;
	logic div_done;
	logic [QUO_W-1:0] quotient;
	logic win_now;
	logic [SPD_W-1:0] limit_now;

	// Request acceptance and operand preparation
	wire accept = edge_valid && edge_ready;
	wire [DEV_W-1:0] abs_dev = dresl_abs(edge_dev);
	wire [DEV_W-1:0] abs_range = dresl_abs(prop_range_setting);
	wire [QUO_W-1:0] dividend = QUO_W'(abs_dev) * QUO_W'(max_auto_speed);
	wire dev_neg = edge_dev[DEV_W-1] ^ prop_range_setting[DEV_W-1];
	assign edge_ready = (state == DRESL_IDLE);

	// Write decode and clamping of written settings
	wire wr_range = wr && (address == OFS_PROP_RANGE);
	wire wr_win = wr && (address == OFS_WIN_PCT);
	wire wr_spd = wr && (address == OFS_SPD_PCT);
	wire wr_max = wr && (address == OFS_MAX_SPEED);
	wire signed [DEV_W-1:0] wsigned = DEV_W'(wdata);
	wire signed [DEV_W-1:0] range_clamped = (wsigned < RANGE_MIN) ? RANGE_MIN :
		(wsigned > RANGE_MAX) ? RANGE_MAX : wsigned;
	wire [SPD_W-1:0] max_clamped = (wdata > DATA_W'(SPEED_LIM)) ? SPEED_LIM :
		wdata[SPD_W-1:0];

	// Clamp the divided speed to the latched limit
	wire over = (quotient > QUO_W'(limit_lat));
	wire [SPD_W-1:0] mag = over ? limit_lat : quotient[SPD_W-1:0];
	wire signed [SPD_W:0] mag_s = {1'b0, mag};
	wire signed [SPD_W:0] next_speed = neg_lat ? -mag_s : mag_s;

	// Read multiplexer
	wire [DATA_W-1:0] status_word = {edge_ready ? 1'b0 : 1'b1, in_window,
		{(DATA_W-SPD_W-2){1'b0}}, limit_lat};
	wire [DATA_W-1:0] read_mux =
		(address == OFS_PROP_RANGE) ? DATA_W'(prop_range_setting) :
		(address == OFS_WIN_PCT) ? DATA_W'(dual_window_percent) :
		(address == OFS_SPD_PCT) ? DATA_W'(dual_speed_percent) :
		(address == OFS_MAX_SPEED) ? DATA_W'(max_auto_speed) :
		(address == OFS_STATUS) ? status_word :
		(address == OFS_LAST_SPEED) ? {{(DATA_W-SPD_W-1){speed_cmd[SPD_W]}}, speed_cmd} :
		'0;

	// Window test and active limit for the sample being accepted
	dresl_limit u_limit (
		.abs_dev(abs_dev),
		.abs_range(abs_range),
		.win_pct(dual_window_percent),
		.spd_pct(dual_speed_percent),
		.max_speed(max_auto_speed),
		.in_window(win_now),
		.limit(limit_now)
	);

	// Gain division: |dev| * max / |range|; a zero range saturates to the limit
	dresl_divider #(
		.N_W(QUO_W),
		.D_W(DEV_W)
	) u_div (
		.clock(clock),
		.rst_n(rst_n),
		.start(accept),
		.dividend(dividend),
		.divisor(abs_range),
		.done(div_done),
		.quotient(quotient)
	);

	// Next state
	always_comb
	begin
		case (state)
			DRESL_IDLE: next_state = accept ? DRESL_DIV : DRESL_IDLE;
			DRESL_DIV: next_state = div_done ? DRESL_IDLE : DRESL_DIV;
			default: next_state = DRESL_IDLE;
		endcase
	end

	// Setting registers, cleared to defaults on reset
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			prop_range_setting <= RANGE_DEF;
			dual_window_percent <= WIN_PCT_DEF;
			dual_speed_percent <= SPD_PCT_DEF;
			max_auto_speed <= SPEED_DEF;
		end
		else
		begin
			if (wr_range)
				prop_range_setting <= range_clamped;
			if (wr_win)
				dual_window_percent <= dresl_clamp_pct(wdata);
			if (wr_spd)
				dual_speed_percent <= dresl_clamp_pct(wdata);
			if (wr_max)
				max_auto_speed <= max_clamped;
		end
	end

	// Sequencer and operand latches
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state <= DRESL_IDLE;
			neg_lat <= 1'b0;
			win_lat <= 1'b0;
			limit_lat <= '0;
		end
		else
		begin
			state <= next_state;
			if (accept)
			begin
				neg_lat <= dev_neg;
				win_lat <= win_now;
				limit_lat <= limit_now;
			end
		end
	end

	// Result registers and read data
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			speed_cmd <= '0;
			speed_valid <= 1'b0;
			in_window <= 1'b0;
			rdata <= '0;
		end
		else
		begin
			speed_valid <= div_done;
			if (div_done)
			begin
				speed_cmd <= next_speed;
				in_window <= win_lat;
			end
			rdata <= rd ? read_mux : '0;
		end
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	logic [SPD_W:0] mag_out;
	assign mag_out = speed_cmd[SPD_W] ? 9'(-speed_cmd) : 9'(speed_cmd);

	AST_GAIN_LATENCY: assert property (accept |-> ##26 speed_valid)
		else $error("speed result not produced 26 cycles after a sample");
	AST_RANGE_BOUND: assert property (prop_range_setting >= RANGE_MIN
		&& prop_range_setting <= RANGE_MAX)
		else $error("proportional range outside its span");
	AST_WIN_PCT_BOUND: assert property (dual_window_percent >= PCT_MIN
		&& dual_window_percent <= PCT_MAX)
		else $error("window percent outside its span");
	AST_REDUCED_CAP: assert property (accept && win_now |-> ##26 speed_valid
		&& mag_out <= 9'(($past(max_auto_speed, 26) * $past(dual_speed_percent, 26)) / 100))
		else $error("speed inside the window exceeds the reduced level");
	AST_FULL_LIMIT: assert property (accept && !win_now |=> limit_lat == $past(max_auto_speed))
		else $error("limit outside the window is not the maximum speed");
	AST_SPD_PCT_BOUND: assert property (dual_speed_percent >= PCT_MIN
		&& dual_speed_percent <= PCT_MAX)
		else $error("speed percent outside its span");
	AST_SYMMETRIC: assert property (accept |=> win_lat ==
		((32'(dresl_abs($past(edge_dev))) * 100)
		<= (32'(dresl_abs($past(prop_range_setting))) * 32'($past(dual_window_percent)))))
		else $error("window decision depends on deviation sign");
	AST_SIGN_FOLLOWS: assert property (speed_valid && mag_out != 9'h000
		|-> speed_cmd[SPD_W] == neg_lat)
		else $error("speed direction does not follow the deviation");
	AST_CLAMPED: assert property (speed_valid |-> mag_out <= 9'(limit_lat))
		else $error("speed magnitude exceeds the active limit");
	AST_BUSY_HOLDS: assert property (accept |=> !edge_ready [*8])
		else $error("new sample accepted during a division");

	COV_IN_WINDOW: cover property (speed_valid && in_window);
	COV_OUT_WINDOW: cover property (speed_valid && !in_window && speed_cmd < 0);
	COV_CLAMP: cover property (div_done && over);
endmodule : dresl_speed_law

//--- dresl_edge_src.sv
// Edge sensor model that offers deviation samples to the speed law
`timescale 1ns/1ps
module dresl_edge_src
	import dresl_pkg::*;
(
	input wire logic clock,
	input wire logic go,
	input wire logic signed [DEV_W-1:0] dev_in,
	input wire logic edge_ready,
	output logic signed [DEV_W-1:0] edge_dev,
	output logic edge_valid
);
	initial
	begin
		edge_valid = 1'b0;
		edge_dev = '0;
	end

	// Hold the sample until taken, then scramble the released lines
	always @(posedge clock)
	begin
		if (go)
		begin
			edge_valid <= 1'b1;
			edge_dev <= dev_in;
		end
		else if (edge_valid && edge_ready)
		begin
			edge_valid <= 1'b0;
			edge_dev <= ~edge_dev;
		end
	end
endmodule : dresl_edge_src

//--- dresl_speed_law_tb.sv
// Self-checking bench for the dual-rate edge speed law
`timescale 1ns/1ps
module dresl_speed_law_tb
	import dresl_pkg::*;
;
	logic clock = 0, rst_n = 0, wr = 0, rd = 0, go = 0;
	logic [ADDR_W-1:0] address = '0;
	logic [DATA_W-1:0] wdata = '0, rdata;
	logic signed [DEV_W-1:0] dev_in = '0, edge_dev;
	logic edge_valid, edge_ready, speed_valid, in_window;
	logic signed [SPD_W:0] speed_cmd;
	int error_cnt = 0, checks_done = 0, cyc = 0;
	int m_rng = 100, m_win = 30, m_spd = 50, m_max = SPEED_DEF, e_lim, e_spd;
	bit e_inw;
	int cl[6][3] = '{'{0, 30000, 20000}, '{0, -30000, -20000}, '{1, 5, 10},
		'{1, 200, 100}, '{2, 9, 10}, '{2, 101, 100}};
	int dv[5] = '{30, -30, 31, -31, 0};

	always #5 clock = ~clock;

	dresl_speed_law uut (.clock(clock), .rst_n(rst_n), .address(address), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .edge_dev(edge_dev), .edge_valid(edge_valid),
		.edge_ready(edge_ready), .speed_cmd(speed_cmd), .speed_valid(speed_valid),
		.in_window(in_window));
	dresl_edge_src src (.clock(clock), .go(go), .dev_in(dev_in), .edge_ready(edge_ready),
		.edge_dev(edge_dev), .edge_valid(edge_valid));

	// Compare one register or count value
	task automatic chk_val(string n, logic [DATA_W-1:0] e, logic [DATA_W-1:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk_val

	// Compare one speed result with its window decision
	task automatic chk_res(logic signed [SPD_W:0] e, bit w);
		checks_done++;
		if ({in_window, speed_cmd} !== {w, e})
		begin
			error_cnt++;
			$display("[ERR] result expected %0d/%0d seen %0d/%b", e, w, speed_cmd, in_window);
		end
	endtask : chk_res

	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	function automatic int clip(int v, int lo, int hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction : clip

	// Register read, data checked in the cycle after the strobe
	task automatic rd_chk(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
		@(posedge clock);
		rd <= 1'b1;
		address <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		chk_val("rdata", e, rdata);
	endtask : rd_chk

	// Register write, the model keeps the clamped setting
	task automatic wr_set(logic [ADDR_W-1:0] a, int v);
		@(posedge clock);
		wr <= 1'b1;
		address <= a;
		wdata <= DATA_W'(v);
		@(posedge clock);
		wr <= 1'b0;
		case (a)
			OFS_PROP_RANGE: m_rng = clip(v, -20000, 20000);
			OFS_WIN_PCT: m_win = clip(v, 10, 100);
			OFS_SPD_PCT: m_spd = clip(v, 10, 100);
			OFS_MAX_SPEED: m_max = clip(v, 0, 180);
			default: ;
		endcase
	endtask : wr_set

	// Expected speed law for one deviation
	task automatic predict(int d);
		int ad, ar, q;
		ad = d < 0 ? -d : d;
		ar = m_rng < 0 ? -m_rng : m_rng;
		e_inw = ad * 100 <= ar * m_win;
		e_lim = e_inw ? m_max * m_spd / 100 : m_max;
		q = ar == 0 ? e_lim : ad * m_max / ar;
		if (q > e_lim)
			q = e_lim;
		e_spd = ((d < 0) != (m_rng < 0)) ? -q : q;
	endtask : predict

	// Offer one sample, time the answer and check the result
	task automatic run(int d);
		int c = -1;
		predict(d);
		@(posedge clock);
		go <= 1'b1;
		dev_in <= DEV_W'(d);
		@(posedge clock);
		go <= 1'b0;
		#1;
		for (int k = 0; k < 60 && speed_valid !== 1'b1; k++)
		begin
			if (c >= 0 || (edge_valid && edge_ready))
				c++;
			@(posedge clock);
			#1;
		end
		// The pulse is seen one edge after the count stops: count that sampling edge too
		chk_val("latency", 16'd26, 16'(c + 1));
		chk_res(9'(e_spd), e_inw);
		rd_chk(OFS_STATUS, {1'b0, e_inw, 6'h00, 8'(e_lim)});
		rd_chk(OFS_LAST_SPEED, 16'(e_spd));
	endtask : run

	// Hang guard
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			print_verdict();
		end
	end

	initial
	begin
		void'($urandom(99704));
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		rd_chk(OFS_PROP_RANGE, 16'h0064);
		rd_chk(OFS_WIN_PCT, 16'h001E);
		rd_chk(OFS_SPD_PCT, 16'h0032);
		rd_chk(4'hF, 16'h0000);
		$display("test defaults done");
		foreach (cl[i])
		begin
			wr_set(4'(cl[i][0]), cl[i][1]);
			rd_chk(4'(cl[i][0]), 16'(cl[i][2]));
		end
		$display("test clamping done");
		wr_set(OFS_PROP_RANGE, 60);
		run(45);
		wr_set(OFS_PROP_RANGE, 105);
		run(45);
		wr_set(OFS_PROP_RANGE, -60);
		run(45);
		$display("test gain done");
		wr_set(OFS_PROP_RANGE, 100);
		wr_set(OFS_WIN_PCT, 30);
		wr_set(OFS_SPD_PCT, 10);
		foreach (dv[i])
			run(dv[i]);
		$display("test dual rate done");
		repeat (25)
		begin
			wr_set(OFS_PROP_RANGE, int'($urandom_range(400)) - 200);
			wr_set(OFS_WIN_PCT, $urandom_range(100, 10));
			wr_set(OFS_SPD_PCT, $urandom_range(100, 10));
			wr_set(OFS_MAX_SPEED, $urandom_range(180));
			run(int'($urandom_range(2000)) - 1000);
		end
		$display("test random done");
		print_verdict();
	end
endmodule : dresl_speed_law_tb
